// >>> logic/counter_tick_gen.sv
// Divider that makes the one-cycle counter clock enable pulse
module counter_tick_gen #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  output logic      tick
);
  localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             tick;
  } tick_state_t;

  tick_state_t s_q;
  tick_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.tick = (s_q.cnt == LAST);
    if (s_q.cnt == LAST) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = s_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule : counter_tick_gen

// >>> logic/flag_bank.sv
// Sticky interrupt flags, set on the counter clock tick after their cause
module flag_bank (
  input wire logic clk_sys,
  input wire logic resetn,
  flag_if.bank     f
);
  import timer_irq_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] pend;
    logic [NUM_CH-1:0] cap_pend;
    logic [DATA_W-1:0] flags;
  } bank_state_t;

  bank_state_t       s_q;
  bank_state_t       s_d;
  logic [DATA_W-1:0] set;

  always_comb begin
    s_d = s_q;
    set = '0;
    if (f.tick) begin
      // Causes seen before this tick become flags; causes in this cycle wait for the next
      set = s_q.pend & FLAG_MASK;
      set[BIT_ERR] = |(s_q.cap_pend & s_q.flags[BIT_MC_LO +: NUM_CH]);
      s_d.pend = f.evt;
      s_d.cap_pend = f.cap;
    end else begin
      s_d.pend = s_q.pend | f.evt;
      s_d.cap_pend = s_q.cap_pend | f.cap;
    end
    // A set in the same cycle as a clear wins
    s_d.flags = ((s_q.flags & ~f.clr) | set) & FLAG_MASK;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{pend: '0, cap_pend: '0, flags: RESET_FLAGS};
    end else begin
      s_q <= s_d;
    end
  end

  assign f.flags = s_q.flags;
endmodule : flag_bank

// >>> logic/flag_if.sv
// Signals between the register front end and the flag bank
interface flag_if;
  logic        tick;
  logic [31:0] evt;
  logic [3:0]  cap;
  logic [31:0] clr;
  logic [31:0] flags;

  modport bank (input tick, input evt, input cap, input clr, output flags);
  modport ctrl (output tick, output evt, output cap, output clr, input flags);
endinterface : flag_if

// >>> logic/timer_irq_enable_and_flags.sv
// Interrupt enable and flag registers of the control timer, Wishbone slave
//
// Added by the designer: the Wishbone slave port.
module timer_irq_enable_and_flags #(
  parameter int unsigned COUNTER_DIV = timer_irq_pkg::COUNTER_DIV_DEFAULT
) (
  input  wire logic                              clk_sys,
  input  wire logic                              resetn,
  input  wire logic                              wb_cyc,
  input  wire logic                              wb_stb,
  input  wire logic                              wb_we,
  input  wire logic [timer_irq_pkg::ADDR_W-1:0]  wb_adr,
  input  wire logic [3:0]                        wb_sel,
  input  wire logic [timer_irq_pkg::DATA_W-1:0]  wb_dat_w,
  output logic      [timer_irq_pkg::DATA_W-1:0]  wb_dat_r,
  output logic                                   wb_ack,
  input  wire logic [timer_irq_pkg::NUM_CH-1:0]  match_capture_channel_evt,
  input  wire logic [timer_irq_pkg::NUM_CH-1:0]  channel_capture_value_evt,
  input  wire logic [timer_irq_pkg::NUM_CH-1:0]  channel_capture_read,
  input  wire logic [timer_irq_pkg::NUM_CH-1:0]  capture_mode,
  input  wire logic [timer_irq_pkg::NUM_NRF-1:0] nonrecoverable_fault_n_evt,
  input  wire logic                              recoverable_fault_a_evt,
  input  wire logic                              recoverable_fault_b_evt,
  input  wire logic                              debug_fault_state_evt,
  input  wire logic                              counter_event_evt,
  input  wire logic                              retrigger_evt,
  input  wire logic                              overflow_evt,
  output logic                                   counter_clock,
  output logic                                   irq
);
  import timer_irq_pkg::*;

  typedef struct packed {
    logic              ack;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] enable;
    logic              irq;
  } reg_state_t;

  reg_state_t        s_q;
  reg_state_t        s_d;
  logic              tick;
  logic              hit;
  logic              do_wr;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] evt;
  logic [DATA_W-1:0] clr;
  flag_if            fl ();

  counter_tick_gen #(
    .DIV (COUNTER_DIV)
  ) u_tick (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tick    (tick)
  );

  flag_bank u_flags (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .f       (fl)
  );

  // Event strobes gathered into flag layout
  always_comb begin
    evt = '0;
    evt[BIT_MC_LO +: NUM_CH] = match_capture_channel_evt | channel_capture_value_evt;
    evt[BIT_NRF_LO +: NUM_NRF] = nonrecoverable_fault_n_evt;
    evt[BIT_FAULT_B] = recoverable_fault_b_evt;
    evt[BIT_FAULT_A] = recoverable_fault_a_evt;
    evt[BIT_DFS] = debug_fault_state_evt;
    evt[BIT_CNT] = counter_event_evt;
    evt[BIT_TRG] = retrigger_evt;
    evt[BIT_OVF] = overflow_evt;
  end

  // Wishbone: ack one cycle after the request, writes act on the acked edge
  always_comb begin
    s_d = s_q;
    hit = wb_cyc & wb_stb;
    s_d.ack = hit & ~s_q.ack;
    do_wr = hit & wb_we & s_q.ack;
    wmask = wb_dat_w & byte_mask(wb_sel) & FLAG_MASK;
    clr = '0;
    if (hit & ~s_q.ack & ~wb_we) begin
      case (wb_adr)
        OFS_ENABLE_CLEAR: s_d.rdata = s_q.enable;
        OFS_ENABLE_SET:   s_d.rdata = s_q.enable;
        OFS_FLAGS:        s_d.rdata = fl.flags;
        OFS_IRQ_STATUS:   s_d.rdata = fl.flags;
        default:          s_d.rdata = '0;
      endcase
    end
    if (do_wr) begin
      case (wb_adr)
        OFS_ENABLE_SET:   s_d.enable = s_q.enable | wmask;
        OFS_ENABLE_CLEAR: s_d.enable = s_q.enable & ~wmask;
        OFS_FLAGS:        clr = wmask;
        OFS_IRQ_CLEAR:    clr = wmask;
        default:          clr = '0;
      endcase
    end
    clr[BIT_MC_LO +: NUM_CH] = clr[BIT_MC_LO +: NUM_CH] | (channel_capture_read & capture_mode);
    s_d.irq = |(fl.flags & s_q.enable);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{ack: 1'b0, rdata: '0, enable: RESET_EN, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign fl.tick = tick;
  assign fl.evt = evt;
  assign fl.cap = channel_capture_value_evt;
  assign fl.clr = clr;

  assign wb_ack = s_q.ack;
  assign wb_dat_r = s_q.rdata;
  assign counter_clock = tick;
  assign irq = s_q.irq;
endmodule : timer_irq_enable_and_flags

// >>> logic/timer_irq_pkg.sv
// Register map, field layout and timing constants of the timer interrupt block
package timer_irq_pkg;
  localparam int unsigned ADDR_W              = 8;
  localparam int unsigned DATA_W              = 32;
  localparam int unsigned NUM_CH              = 4;
  localparam int unsigned NUM_NRF             = 2;
  localparam int unsigned COUNTER_DIV_DEFAULT = 2;

  localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_SET   = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_FLAGS        = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS   = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR    = 8'h3C;

  localparam int unsigned BIT_MC_LO      = 16;
  localparam int unsigned BIT_NRF_LO     = 14;
  localparam int unsigned BIT_FAULT_B    = 13;
  localparam int unsigned BIT_FAULT_A    = 12;
  localparam int unsigned BIT_DFS        = 11;
  localparam int unsigned BIT_ERR        = 3;
  localparam int unsigned BIT_CNT        = 2;
  localparam int unsigned BIT_TRG        = 1;
  localparam int unsigned BIT_OVF        = 0;

  localparam logic [DATA_W-1:0] FLAG_MASK   = 32'h000F_F80F;
  localparam logic [DATA_W-1:0] RESET_FLAGS = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RESET_EN    = 32'h0000_0000;

  // Expands Wishbone byte selects to a bit mask
  function automatic logic [DATA_W-1:0] byte_mask(input logic [3:0] sel);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{sel[i]}};
    end
    return m;
  endfunction : byte_mask
endpackage : timer_irq_pkg

// >>> testbench/timer_irq_enable_and_flags_sva.sv
// Port-level assertions for the timer interrupt block
module timer_irq_enable_and_flags_sva #(
  parameter int unsigned COUNTER_DIV = 2
) (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_we,
  input wire logic [7:0]  wb_adr,
  input wire logic [31:0] wb_dat_r,
  input wire logic        wb_ack,
  input wire logic [3:0]  channel_capture_read,
  input wire logic [3:0]  capture_mode,
  input wire logic        counter_clock,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import timer_irq_pkg::*;
  int tk_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) tk_q <= 0;
    else tk_q <= counter_clock ? 1 : tk_q + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_ack_req; wb_cyc && wb_stb && !wb_ack |=> wb_ack; endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack");
  property p_ack_one; wb_ack |=> !wb_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  property p_ack_cause; wb_ack |-> $past(wb_cyc && wb_stb); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
  property p_tick; counter_clock == (tk_q == COUNTER_DIV); endproperty
  a_tick: assert property (p_tick) else $error("tick period");
  property p_irq_rise; $rose(irq) |-> $past(wb_ack, 2) || $past(counter_clock, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rise");
  property p_irq_fall;
    $fell(irq) |-> $past(wb_ack, 2) || $past(|(channel_capture_read & capture_mode), 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fall");
  property p_rd_mask; wb_ack && !$past(wb_we) |-> (wb_dat_r & ~FLAG_MASK) == '0; endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("bits outside mask");
  property p_rd_clr;
    wb_ack && !$past(wb_we) && $past(wb_adr) == OFS_IRQ_CLEAR |-> wb_dat_r == '0;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("clear reg read");
  c_irq: cover property ($rose(irq));
  c_crd: cover property (|(channel_capture_read & capture_mode));
  c_rd: cover property (wb_ack && !wb_we);
endmodule : timer_irq_enable_and_flags_sva

// >>> testbench/timer_irq_enable_and_flags_tb.sv
// Self-checking bench for the timer interrupt block
module timer_irq_enable_and_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_irq_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = '0;
  logic [31:0] wb_dat_w = '0, ev = '0, rdat, e_v, wb_dat_r;
  logic [3:0]  cap = '0, crd = '0, cmode = '0, sel = 4'hF;
  logic        wb_ack, counter_clock, irq;
  int          bad_count = 0, num_checks = 0;
  timer_irq_enable_and_flags #(.COUNTER_DIV(2)) u_timer_irq_enable_and_flags (
    .clk_sys, .resetn, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel(sel), .wb_dat_w,
    .wb_dat_r, .wb_ack, .match_capture_channel_evt(ev[19:16]),
    .channel_capture_value_evt(cap), .channel_capture_read(crd), .capture_mode(cmode),
    .nonrecoverable_fault_n_evt(ev[15:14]), .recoverable_fault_a_evt(ev[12]),
    .recoverable_fault_b_evt(ev[13]), .debug_fault_state_evt(ev[11]),
    .counter_event_evt(ev[2]), .retrigger_evt(ev[1]), .overflow_evt(ev[0]),
    .counter_clock, .irq);
  always #50 clk_sys = ~clk_sys;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      print_verdict();
    end
    rdat = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, '0);
    chk(nm, e, rdat);
  endtask : rd
  task automatic pulse(input logic [31:0] v, input logic [3:0] c, input logic [3:0] r);
    ev <= v;
    cap <= c;
    crd <= r;
    @(posedge clk_sys);
    ev <= '0;
    cap <= '0;
    crd <= '0;
    repeat (6) @(posedge clk_sys);
  endtask : pulse
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_sys);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask : irq_is
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(OFS_ENABLE_SET, RESET_EN, "en_rst");
    rd(OFS_FLAGS, RESET_FLAGS, "flag_rst");
    $display("reset test done");
    wb(1'b1, OFS_ENABLE_SET, 32'h0000_A00A);
    rd(OFS_ENABLE_CLEAR, 32'h0000_A00A, "en_view");
    wb(1'b1, OFS_ENABLE_SET, 32'h0000_5805);
    rd(OFS_ENABLE_SET, 32'h0000_F80F, "en_set");
    wb(1'b1, OFS_ENABLE_CLEAR, FLAG_MASK);
    rd(OFS_ENABLE_SET, 32'h0, "en_shared");
    sel <= 4'h1;
    wb(1'b1, OFS_ENABLE_SET, FLAG_MASK);
    sel <= 4'hF;
    rd(OFS_ENABLE_SET, 32'h0000_000F, "en_lane");
    wb(1'b1, OFS_ENABLE_CLEAR, FLAG_MASK);
    rd(OFS_ENABLE_SET, 32'h0, "en_lane_clr");
    $display("enable test done");
    pulse(32'h000F_F807, '0, '0);
    wb(1'b1, OFS_FLAGS, 32'h0);
    e_v = 32'h000F_F807;
    rd(OFS_FLAGS, e_v, "flag_set");
    for (int i = 0; i < 20; i++) begin
      if (e_v[i]) begin
        e_v[i] = 1'b0;
        wb(1'b1, OFS_FLAGS, 32'h1 << i);
        rd(OFS_FLAGS, e_v, "flag_w1c");
      end
    end
    $display("flag test done");
    wb(1'b1, OFS_ENABLE_SET, 32'h1);
    pulse(32'h1, '0, '0);
    irq_is(1'b1);
    wb(1'b1, OFS_ENABLE_CLEAR, 32'h1);
    irq_is(1'b0);
    wb(1'b1, OFS_ENABLE_SET, 32'h1);
    irq_is(1'b1);
    wb(1'b1, OFS_IRQ_CLEAR, 32'h1);
    irq_is(1'b0);
    $display("irq test done");
    pulse('0, 4'h1, '0);
    pulse('0, 4'h1, '0);
    rd(OFS_IRQ_STATUS, 32'h0001_0008, "cap_err");
    pulse('0, '0, 4'h1);
    rd(OFS_FLAGS, 32'h0001_0008, "cap_read_cmp");
    cmode <= 4'h1;
    pulse('0, '0, 4'h1);
    rd(OFS_FLAGS, 32'h8, "cap_read");
    wb(1'b1, OFS_FLAGS, 32'h8);
    rd(OFS_FLAGS, 32'h0, "err_clr");
    rd(8'h00, 32'h0, "unmapped");
    rd(OFS_IRQ_CLEAR, 32'h0, "clr_read");
    $display("capture test done");
    print_verdict();
  end
  initial begin
    #(5000 * 100);
    bad_count++;
    print_verdict();
  end
endmodule : timer_irq_enable_and_flags_tb
bind timer_irq_enable_and_flags timer_irq_enable_and_flags_sva #(.COUNTER_DIV(COUNTER_DIV))
  u_timer_irq_enable_and_flags_sva (.clk_sys, .resetn, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
  .wb_dat_r, .wb_ack, .channel_capture_read, .capture_mode, .counter_clock, .irq);
